// [shared/rca_pkg.sv]
// Purpose: constants and carriers for the cascade arbitration block
// Assumes: 13 ports, one bit time is 100 ns (10 MHz serial rate)
// Notes:   cascade bus lines are active high inside the core
package rca_pkg;
  localparam int RCA_PORTS      = 13;
  localparam int RCA_MIN_BITS   = 96;   // least transmit length in bits
  localparam int RCA_PRE_BITS   = 64;   // generated preamble incl. delimiter
  localparam int RCA_TW1_BITS   = 96;   // transmit recovery in bits
  localparam int RCA_TW2_BITS   = 4;    // collision extension in bits
  localparam int RCA_START_BITS = 2;    // start-up delay for arbitration
  localparam int RCA_BIT_NS     = 100;  // bit time
  localparam int RCA_CLK_NS     = 10;
  localparam int RCA_CYC_PER_BIT =
    (RCA_BIT_NS + RCA_CLK_NS - 1) / RCA_CLK_NS;
  localparam logic [7:0] RCA_SFD = 8'hd5; // delimiter as received lsb first
  // synchroniser value after reset: {chain_in, activity, collision}
  localparam logic [2:0] RCA_SYNC_RST = 3'h4;

  typedef enum logic [4:0] {
    RCA_IDLE    = 5'h01,
    RCA_START   = 5'h02,
    RCA_REPEAT  = 5'h04,
    RCA_RXCOL   = 5'h08,
    RCA_WAIT    = 5'h10
  } rca_state_e;

  // cascade serial group, one bit per link clock
  typedef struct packed {
    logic data;
    logic enable;
  } rca_ser_s;

  // chip outputs toward the segments
  typedef struct packed {
    logic [RCA_PORTS-1:0] tx_en;
    logic                 tx_jam;   // sending jam or preamble pattern
    logic                 tx_data;  // buffered data bit when not jam
  } rca_seg_s;
endpackage : rca_pkg

// [verilog/rca_core.sv]
// Purpose: cascade arbitration and repeat control for one repeater chip
// Assumes: port activity inputs are asynchronous; link clock from holder
// Notes:   jam and preamble share one alternating pattern generator
`timescale 1ns/1ns
module rca_core
  import rca_pkg::*;
#(
  parameter int PORTS = RCA_PORTS
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             link_clk,       // cascade bit clock in
  input  wire logic [PORTS-1:0] port_rx,        // receive activity per port
  input  wire logic [PORTS-1:0] port_col,       // collision per port
  input  wire logic [PORTS-1:0] port_dec_data,  // decoded nrz per port
  input  wire logic             dec_locked,     // decoder locked on holder
  input  wire logic             tx_collision,   // repeater in tx collision
  input  wire logic             chain_in,
  output logic                  chain_out,
  input  wire logic             port_activity_bus_in,
  output logic                  port_activity_bus_out,
  output logic                  port_activity_bus_oe,  // low = driving
  input  wire logic             collision_bus_line_in,
  output logic                  collision_bus_line_out,
  output logic                  collision_bus_line_oe,
  input  rca_ser_s              cascade_in,
  output rca_ser_s              cascade_out,
  output logic                  cascade_oe,
  output logic                  cascade_bit_clock_en,
  output rca_seg_s              seg,
  output logic                  bus_repeat,     // bus state: repeat vs idle
  output logic [3:0]            holder_port     // 0 = none, else 1..13
);
  // holder_port and the bit phase counter are four bits wide
  if (PORTS < 1 || PORTS > 15 || RCA_CYC_PER_BIT > 16) begin : g_chk
    $error("rca_core: PORTS or bit timing out of range");
  end

  localparam int START_CYC = RCA_START_BITS * RCA_CYC_PER_BIT;
  localparam int MIN_CYC   = RCA_MIN_BITS * RCA_CYC_PER_BIT;
  localparam int PRE_CYC   = RCA_PRE_BITS * RCA_CYC_PER_BIT;
  localparam int TW1_CYC   = RCA_TW1_BITS * RCA_CYC_PER_BIT;
  localparam int TW2_CYC   = RCA_TW2_BITS * RCA_CYC_PER_BIT;

  // highest-priority set bit, port 1 at bit 0; 0 when none
  function automatic logic [3:0] rca_first(input logic [PORTS-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = PORTS - 1; i >= 0; i--) begin
      if (v[i]) r = 4'(i + 1);
    end
    return r;
  endfunction : rca_first

  // two-flop synchronisers for all asynchronous inputs
  logic [PORTS-1:0] rx_m, rx_s, col_m, col_s;
  logic [2:0]       misc_m, misc_s;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_m   <= '0;
      rx_s   <= '0;
      col_m  <= '0;
      col_s  <= '0;
      // chain_in idles high; a zero here would fake a falling chain edge
      misc_m <= RCA_SYNC_RST;
      misc_s <= RCA_SYNC_RST;
    end else begin
      rx_m   <= port_rx;
      rx_s   <= rx_m;
      col_m  <= port_col;
      col_s  <= col_m;
      misc_m <= {chain_in, port_activity_bus_in, collision_bus_line_in};
      misc_s <= misc_m;
    end
  end
  logic ch_in_s, act_s, collision_bus_line_s;
  assign ch_in_s = misc_s[2];
  assign act_s   = misc_s[1];
  assign collision_bus_line_s  = misc_s[0];

  // main repeat state machine
  rca_state_e state, next_state;
  logic [11:0] cnt, next_cnt;         // cycles in current state; RXCOL carries on the REPEAT count
  logic [11:0] sent, next_sent;       // cycles transmitted since start
  logic [11:0] ext, next_ext;         // tw2 extension counter
  logic [3:0]  holder, next_holder;
  logic        jam, next_jam;
  logic        active_any;
  logic [3:0]  rx_pick, col_pick;
  logic        own_hold;
  logic        local_act;

  assign rx_pick    = rca_first(rx_s | col_s);
  assign col_pick   = rca_first(col_s);
  assign own_hold   = (holder != 4'h0);
  // a foreign holder is seen through the shared activity line, and in idle also through a low chain_in
  assign active_any = act_s;
  assign local_act  = own_hold &&
                      (rx_s[holder-1] || col_s[holder-1]);

  always_comb begin
    next_state  = state;
    next_cnt    = cnt + 12'h001;
    next_sent   = (state == RCA_IDLE || state == RCA_WAIT) ?
                  12'h000 : ((sent == 12'hfff) ? sent : sent + 12'h001);
    next_ext    = ext;
    next_holder = holder;
    next_jam    = jam;
    unique case (state)
      RCA_IDLE: begin
        next_jam = 1'b0;
        // chain entry is the top of the priority chain
        if (ch_in_s && rx_pick != 4'h0) begin
          next_holder = rx_pick;
          next_state  = RCA_START;
          next_cnt    = 12'h000;
        end else if (active_any || !ch_in_s) begin
          next_holder = 4'h0;
          next_state  = RCA_START;
          next_cnt    = 12'h000;
        end
      end
      RCA_START: begin
        // arbitration settles inside the start-up delay
        if (cnt == 12'(START_CYC - 1)) begin
          next_state = RCA_REPEAT;
          next_cnt   = 12'h000;
        end
      end
      RCA_REPEAT: begin
        if (tx_collision && col_pick != 4'h0)
          next_holder = col_pick;
        if (collision_bus_line_s || (own_hold && col_s[holder-1])) begin
          next_jam   = 1'b1;
          next_state = RCA_RXCOL;
          next_ext   = 12'(TW2_CYC);
        end else if (!active_any && !local_act) begin
          if (sent < 12'(MIN_CYC)) begin
            next_jam   = 1'b1;
            next_state = RCA_RXCOL;
            next_ext   = 12'h000;
          end else begin
            next_state  = RCA_WAIT;
            next_cnt    = 12'h000;
            next_holder = 4'h0;
          end
        end
      end
      RCA_RXCOL: begin
        next_jam = 1'b1;
        // collision end restarts the tw2 extension; covers all three
        // orderings of receive and collision ending
        if (collision_bus_line_s || (own_hold && col_s[holder-1]))
          next_ext = 12'(TW2_CYC);
        else if (ext != 12'h000)
          next_ext = ext - 12'h001;
        if (sent >= 12'(MIN_CYC) && ext == 12'h000 &&
            !collision_bus_line_s && !active_any && !local_act) begin
          next_state  = RCA_WAIT;
          next_cnt    = 12'h000;
          next_holder = 4'h0;
        end
      end
      RCA_WAIT: begin
        next_jam = 1'b0;
        if (cnt == 12'(TW1_CYC - 1)) begin
          next_state = RCA_IDLE;
          next_cnt   = 12'h000;
        end
      end
      default: begin
        next_state  = RCA_IDLE;
        next_holder = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state  <= RCA_IDLE;
      cnt    <= 12'h000;
      sent   <= 12'h000;
      ext    <= 12'h000;
      holder <= 4'h0;
      jam    <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      sent   <= next_sent;
      ext    <= next_ext;
      holder <= next_holder;
      jam    <= next_jam;
    end
  end

  // chain and bus drivers; holder pulls chain_out low with chain_in high
  logic pre_done;
  logic sfd_seen_s;
  logic bit_sys;
  logic next_chain_out, next_act_out, next_collision_bus_line_out;
  always_comb begin
    next_chain_out = ch_in_s && !own_hold && (rx_pick == 4'h0);
    if (state == RCA_IDLE && rx_pick != 4'h0)
      next_chain_out = 1'b0;
    next_act_out  = own_hold && local_act;
    next_collision_bus_line_out = own_hold && col_s[holder-1];
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chain_out              <= 1'b1;
      port_activity_bus_out  <= 1'b0;
      collision_bus_line_out <= 1'b0;
    end else begin
      chain_out              <= next_chain_out;
      port_activity_bus_out  <= next_act_out;
      collision_bus_line_out <= next_collision_bus_line_out;
    end
  end
  assign port_activity_bus_oe  = !(own_hold && local_act);
  assign collision_bus_line_oe = !own_hold;

  // holder sends decoded data after lock; stopped after collision
  logic drive_ser, next_drive_ser;
  logic ser_bit, next_ser_bit;
  always_comb begin
    next_drive_ser = own_hold && dec_locked && !jam &&
                     state == RCA_REPEAT;
    next_ser_bit   = own_hold ? port_dec_data[holder-1] : 1'b0;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drive_ser <= 1'b0;
      ser_bit   <= 1'b0;
    end else begin
      drive_ser <= next_drive_ser;
      ser_bit   <= next_ser_bit;
    end
  end
  assign cascade_out.data      = ser_bit;
  assign cascade_out.enable    = drive_ser;
  assign cascade_oe            = !drive_ser;
  assign cascade_bit_clock_en  = drive_ser;

  // link logic is cleared from the system side between frames: the link
  // clock stands still outside frames, so a dropped enable is never
  // clocked in and the delimiter flag would carry into the next frame
  logic ser_clr, next_ser_clr;
  logic link_rst;
  assign next_ser_clr = (state == RCA_IDLE || state == RCA_WAIT);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ser_clr <= 1'b1;
    end else begin
      ser_clr <= next_ser_clr;
    end
  end
  assign link_rst = reset || ser_clr;

  // link domain: delimiter hunt on cascade stream, then load one bit
  logic [7:0] shreg, next_shreg;
  logic       sfd_l, next_sfd_l;
  logic       lbit, next_lbit;
  logic       ltog, next_ltog;
  always_comb begin
    next_shreg = {cascade_in.data, shreg[7:1]};
    next_sfd_l = sfd_l;
    next_lbit  = lbit;
    next_ltog  = ltog;
    if (!cascade_in.enable) begin
      next_sfd_l = 1'b0;
    end else if (!sfd_l) begin
      if (next_shreg == RCA_SFD) next_sfd_l = 1'b1;
    end else begin
      next_lbit = cascade_in.data;
      next_ltog = ~ltog;
    end
  end
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      shreg <= 8'h00;
      sfd_l <= 1'b0;
      lbit  <= 1'b0;
      ltog  <= 1'b0;
    end else begin
      shreg <= next_shreg;
      sfd_l <= next_sfd_l;
      lbit  <= next_lbit;
      ltog  <= next_ltog;
    end
  end

  // crossing: level sync for delimiter, toggle handshake for each bit
  logic [1:0] sfd_sync, tog_sync;
  logic       tog_q, bit_q, next_bit_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sfd_sync <= 2'b00;
      tog_sync <= 2'b00;
      tog_q    <= 1'b0;
      bit_q    <= 1'b0;
    end else begin
      sfd_sync <= {sfd_sync[0], sfd_l};
      tog_sync <= {tog_sync[0], ltog};
      tog_q    <= tog_sync[1];
      bit_q    <= next_bit_q;
    end
  end
  // bit changes on the same link edge as the toggle, then holds for a whole link period
  assign next_bit_q = (tog_sync[1] != tog_q) ? lbit : bit_q;
  assign sfd_seen_s = sfd_sync[1];
  assign bit_sys    = bit_q;

  // segment output: preamble first, buffered data only when ready
  logic       pat, next_pat;
  logic [3:0] bph, next_bph;        // clock cycle within the bit time
  rca_seg_s   next_seg;
  assign pre_done = (sent >= 12'(PRE_CYC));
  always_comb begin
    next_bph = (state == RCA_IDLE || bph == 4'(RCA_CYC_PER_BIT - 1)) ?
               4'h0 : bph + 4'h1;
    // jam and preamble alternate once per bit time, not once per clock
    next_pat = (state == RCA_IDLE) ? 1'b0 :
               ((bph == 4'(RCA_CYC_PER_BIT - 1)) ? ~pat : pat);
    next_seg.tx_en = '0;
    if (state == RCA_REPEAT || state == RCA_RXCOL) begin
      for (int i = 0; i < PORTS; i++)
        next_seg.tx_en[i] = (4'(i + 1) != holder) || jam;
    end
    // data is sent after preamble and delimiter lock, never on collision
    next_seg.tx_jam  = jam || !pre_done || !sfd_seen_s;
    next_seg.tx_data = next_seg.tx_jam ? pat : bit_sys;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pat        <= 1'b0;
      bph        <= 4'h0;
      seg        <= '0;
      bus_repeat <= 1'b0;
    end else begin
      pat        <= next_pat;
      bph        <= next_bph;
      seg        <= next_seg;
      bus_repeat <= (state == RCA_REPEAT || state == RCA_RXCOL);
    end
  end
  assign holder_port = holder;

  // checks on the main sequencing
  wait_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state == RCA_WAIT) |-> (state == RCA_WAIT) [*8])
    else $error("wait state too short");
  min_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_RXCOL && next_state == RCA_WAIT) |->
      sent >= 12'(MIN_CYC))
    else $error("left collision before 96 bits");
  jam_col_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_REPEAT && collision_bus_line_s) |=> jam ##1 seg.tx_jam)
    else $error("collision did not force jam");
  jam_own_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_REPEAT && own_hold && col_s[holder-1]) |=>
      jam ##1 seg.tx_jam)
    else $error("own collision did not force jam");
  start_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state == RCA_START) |-> ##[1:2] state != RCA_IDLE)
    else $error("start-up left too soon");
  no_ser_col_a: assert property (@(posedge sys_clk) disable iff (reset)
    jam |=> !drive_ser)
    else $error("cascade driven during jam");
  prio_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_IDLE && ch_in_s && rx_pick != 4'h0) |=>
      holder == $past(rx_pick))
    else $error("wrong receiving port");
  chain_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (own_hold && ch_in_s) |=> !chain_out)
    else $error("holder chain_out not low");
  bus_state_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_REPEAT) |=> bus_repeat)
    else $error("bus state not repeat");
  pre_first_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == RCA_REPEAT && !pre_done) |=> seg.tx_jam)
    else $error("data before preamble");
  act_own_a: assert property (@(posedge sys_clk) disable iff (reset)
    !own_hold |-> port_activity_bus_oe)
    else $error("activity driven by non-holder");

  repeat_c: cover property (@(posedge sys_clk) disable iff (reset)
    state == RCA_REPEAT ##1 state == RCA_WAIT);
  rxcol_c: cover property (@(posedge sys_clk) disable iff (reset)
    state == RCA_RXCOL ##1 state == RCA_WAIT);
  frag_c: cover property (@(posedge sys_clk) disable iff (reset)
    state == RCA_REPEAT && !jam ##1 state == RCA_RXCOL && ext == 12'h000);
  col_c: cover property (@(posedge sys_clk) disable iff (reset)
    state == RCA_REPEAT ##1 state == RCA_RXCOL && ext != 12'h000);
endmodule : rca_core

// [sim/rca_partner.sv]
// Purpose: far chip holding the receiving port, drives the cascade stream
// Assumes: one frame per rise of go; link clock stands still outside frames
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ns
module rca_partner
  import rca_pkg::*;
#(
  parameter int DATA_BITS = 64
) (
  input  wire logic go,
  output logic      link_clk,
  output rca_ser_s  cascade_in,
  output logic      busy
);
  // preamble lsb first, delimiter, then a changing data pattern
  function automatic logic frame_bit(int i);
    if (i < 56) return ~i[0];
    if (i < 64) return RCA_SFD[i-56];
    return i[1] ^ i[3];
  endfunction : frame_bit

  // data changes while the clock is low, so each rising edge sees it settled
  initial begin
    link_clk   = 1'b0;
    cascade_in = '0;
    busy       = 1'b0;
    forever begin
      wait (go);
      busy = 1'b1;
      for (int i = 0; i < 64 + DATA_BITS; i++) begin
        cascade_in.data   = frame_bit(i);
        cascade_in.enable = 1'b1;
        #63 link_clk = 1'b1;
        #62 link_clk = 1'b0;
      end
      cascade_in.enable = 1'b0;
      cascade_in.data   = ~cascade_in.data;
      busy = 1'b0;
      wait (!go);
    end
  end
endmodule : rca_partner

// [sim/rca_core_bench.sv]
// Purpose: self-checking bench for the cascade arbitration core
// Assumes: single chip, top of the chain except in t_chain_low; partner as stream source
// Notes:   wired-or bus lines are resolved here from all drivers
`timescale 1ns/1ns
module rca_core_bench;
  import rca_pkg::*;
  logic        sys_clk, reset, link_clk, dec_locked, tx_collision;
  logic [12:0] port_rx, port_col, port_dec_data;
  logic        chain_in, chain_out, go, busy, other_act;
  logic        act_out, act_oe, act_in, col_out, col_oe, col_in;
  logic        cascade_oe, clk_en, bus_repeat;
  logic [3:0]  holder_port;
  rca_ser_s    cascade_in, cascade_out;
  rca_seg_s    seg;
  int          fails, samples_checked, cyc;

  // open-drain style lines: any driving party pulls the line active
  assign act_in = (~act_oe & act_out) | other_act;
  assign col_in = ~col_oe & col_out;

  rca_core rca_core_i (.sys_clk(sys_clk), .reset(reset),
    .link_clk(link_clk), .port_rx(port_rx), .port_col(port_col),
    .port_dec_data(port_dec_data), .dec_locked(dec_locked),
    .tx_collision(tx_collision), .chain_in(chain_in),
    .chain_out(chain_out), .port_activity_bus_in(act_in),
    .port_activity_bus_out(act_out), .port_activity_bus_oe(act_oe),
    .collision_bus_line_in(col_in), .collision_bus_line_out(col_out),
    .collision_bus_line_oe(col_oe), .cascade_in(cascade_in),
    .cascade_out(cascade_out), .cascade_oe(cascade_oe),
    .cascade_bit_clock_en(clk_en), .seg(seg), .bus_repeat(bus_repeat),
    .holder_port(holder_port));
  rca_partner rca_partner_i (.go(go), .link_clk(link_clk),
    .cascade_in(cascade_in), .busy(busy));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // bounded wait on a chosen condition; running out ends the run
  task automatic wait_until(int k, int lim);
    int n;
    n = 0;
    while (!((k == 0 && chain_out === 1'b0) ||
             (k == 1 && bus_repeat === 1'b1) ||
             (k == 2 && bus_repeat === 1'b0) ||
             (k == 3 && seg.tx_jam === 1'b0) ||
             (k == 4 && col_out === 1'b1) ||
             (k == 5 && busy === 1'b0))) begin
      tick(1);
      if (++n > lim) begin
        fails++;
        $display("ERROR %0t wait %0d timed out", $time, k);
        final_report();
      end
    end
  endtask : wait_until

  task automatic t_reset;
    check({chain_out, act_oe, col_oe, cascade_oe}, 16'h000f);
    check({bus_repeat, holder_port}, 16'h0000);
  endtask : t_reset

  // two ports at once: the higher one wins, the other is made to send
  task automatic t_priority;
    logic b;
    port_rx = 13'h0044;
    wait_until(0, 10);
    check(holder_port, 16'h0003);
    tick(1);
    check({act_out, act_oe}, 16'h0002);
    wait_until(1, 30);
    check(seg.tx_en, 16'h1ffb);
    check(seg.tx_jam, 16'h0001);
    b = seg.tx_data;
    tick(10);
    check(seg.tx_data, 16'(!b));
    port_rx = '0;
    tick(500);
    check(bus_repeat, 16'h0001);
    wait_until(2, 1000);
    port_rx = 13'h0001;
    tick(100);
    check(holder_port, 16'h0000);
    port_rx = '0;
    tick(1100);
  endtask : t_priority

  // a higher chip holds the chain: this chip must not claim
  task automatic t_chain_low;
    chain_in  = 1'b0;
    other_act = 1'b1;
    port_rx   = 13'h0008;
    tick(10);
    check({holder_port, act_oe}, 16'h0001);
    wait_until(1, 30);
    tick(100);
    check({bus_repeat, cascade_oe}, 16'h0003);
    check(seg.tx_en, 16'h1fff);
    port_rx   = '0;
    other_act = 1'b0;
    chain_in  = 1'b1;
    wait_until(2, 1100);
    tick(1100);
  endtask : t_chain_low

  // full frame: preamble generated first, data only after the delimiter
  task automatic t_data;
    int t0;
    go = 1'b1;
    port_rx = 13'h0002;
    dec_locked = 1'b1;
    wait_until(1, 30);
    t0 = cyc;
    check(seg.tx_jam, 16'h0001);
    tick(100);
    check({cascade_oe, clk_en}, 16'h0001);
    check({cascade_out.enable, cascade_out.data}, 16'h0003);
    wait_until(3, 2000);
    check(cyc - t0 >= 640, 16'h0001);
    wait_until(5, 2000);
    port_rx = '0;
    dec_locked = 1'b0;
    go = 1'b0;
    wait_until(2, 2000);
    tick(1100);
  endtask : t_data

  // collision on the receiving port: line raised, jam on all segments
  task automatic t_rxcol;
    port_rx = 13'h0010;
    wait_until(1, 30);
    tick(50);
    port_col = 13'h0010;
    wait_until(4, 10);
    check({col_oe, seg.tx_jam}, 16'h0001);
    port_col = '0;
    port_rx  = '0;
    tick(20);
    check(bus_repeat, 16'h0001);
    wait_until(2, 1100);
    tick(1100);
  endtask : t_rxcol

  // transmit collision: highest colliding port named, and still held after it ends
  task automatic t_txcol;
    port_rx = 13'h0080;
    wait_until(1, 30);
    tx_collision = 1'b1;
    port_col = 13'h0600;
    port_rx  = '0;
    tick(50);
    tx_collision = 1'b0;
    tick(10);
    check(holder_port, 16'h000a);
    port_col = '0;
    wait_until(2, 1200);
    tick(1100);
  endtask : t_txcol

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    cyc = 0;
    fails = 0;
    samples_checked = 0;
    port_rx = '0;
    port_col = '0;
    port_dec_data = 13'h0aaa;
    dec_locked = 1'b0;
    tx_collision = 1'b0;
    chain_in = 1'b1;
    go = 1'b0;
    other_act = 1'b0;
    tick(5);
    t_reset();
    reset = 1'b0;
    tick(5);
    t_reset();
    t_priority();
    t_chain_low();
    t_data();
    t_rxcol();
    t_txcol();
    final_report();
  end
endmodule : rca_core_bench
